// ==== verilog/ucsm_uart.v ====
// UART control, status, shifters and handshake lines
`timescale 1ns/100ps
`include "ucsm_defines.vh"

// ----------------------------------------
// Two-entry data buffer
// ----------------------------------------
module ucsm_buf #(
   parameter W     = 8,
   parameter DEPTH = 2,
   parameter AW    = 1
) (
   input  wire         mclk_i,
   input  wire         reset_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire         push = in_valid_i & in_ready_o;
   wire         pop  = out_valid_o & out_ready_i;
   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = mem_q[rp_q];
   always @(posedge mclk_i) begin
      if (push)
         mem_q[wp_q] <= in_data_i;
      if (reset_i) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         if (pop)
            rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// Behaviour
// - Status bit 15 high during one bit period after core reset.
// - Status bit 13 reads one while receiver is not shifting a frame.
// - Status bit 16 reads one while transmitter is not shifting a frame.
// - Status bits 12 and 14 show receive and transmit bit clock levels.
// - Receive data read gives character in bits 0-7, upper bits zero.
// - Transmit data write takes bits 0-7, ignores upper bits.
// - Control bits 0 and 1 enable receiver and transmitter, reset zero.
// - Control bit 2 adds parity, bit 3 picks even over odd.
// - Control bit 4 selects two stop bits instead of one.
// - Control bits 5 and 6 give data length five to eight bits.
// - Control bits 9-12 pick one of fourteen listed bit rates.
// - Unlisted rate codes run at 7812.5 baud.
// - Control bits 13 and 14 gate receive and transmit interrupts.
// - Control bit 15 holds the transmit line low for break.
// - Modem bit 3 makes carrier detect an output.
// - Modem bit 4 makes request-to-send an output.
// - Modem bit 5 makes terminal-ready an output.
// - Modem bit 0 drives terminal-ready or reads incoming data-set-ready.
// - Modem bits 1 and 2 give driven send and carrier levels.
// - Bit rate prescalers derive from module clock frequency parameter.
// - Without modem support handshake outputs sit high, directions ignored.
// - Interrupts set per character, clear on control or receive data read.
module ucsm_uart #(
   parameter MODULE_CLOCK_HZ = `UCSM_CLK_HZ,
   parameter MODEM_EN        = 0,
   parameter BUF_DEPTH       = 2,
   parameter BUF_AW          = 1,
   parameter CW              = 24
) (
   input  wire        mclk_i,
   input  wire        reset_i,
   input  wire [2:0]  reg_addr_i,
   input  wire [17:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [17:0] reg_rdata_o,
   input  wire        rxd_i,
   output reg         txd_o,
   output reg         rx_irq_o,
   output reg         tx_irq_o,
   input  wire        dcd_i,
   output reg         dcd_o,
   output reg         dcd_oe_o,
   input  wire        rts_i,
   output reg         rts_o,
   output reg         rts_oe_o,
   input  wire        dtr_i,
   output reg         dtr_o,
   output reg         dtr_oe_o
);
   localparam S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h2, S_PAR = 3'h3, S_STOP = 3'h4;

   // ----------------------------------------
   // Registers and pin synchronisers
   // ----------------------------------------
   reg [17:0]   ctrl_q;
   reg [5:0]    modem_q;
   reg [3:0]    s1_q;
   reg [3:0]    s2_q;
   reg          rst_q;
   reg [CW-1:0] rst_cnt_q;
   reg          rx_irq_q;
   reg          tx_irq_q;
   reg          perr_q;
   reg          ferr_q;
   reg          derr_q;
   wire rxd = s2_q[0];
   wire dcd_in = s2_q[1];
   wire cts_in = s2_q[2];
   wire dsr_in = s2_q[3];
   wire wr_ctrl = reg_wr_i & (reg_addr_i == `UCSM_OFS_CTRL);
   wire rd_ctrl = reg_rd_i & (reg_addr_i == `UCSM_OFS_CTRL);
   wire rd_rx   = reg_rd_i & (reg_addr_i == `UCSM_OFS_RXDATA);
   wire wr_tx   = reg_wr_i & (reg_addr_i == `UCSM_OFS_TXDATA);

   // ----------------------------------------
   // Bit period from rate code
   // ----------------------------------------
   function [CW-1:0] div_of;
      input [3:0] c;
      reg [31:0] d;
      reg [31:0] b;
      begin
         case (c)
            4'h0: b = `UCSM_BAUD_0;
            4'h1: b = `UCSM_BAUD_1;
            4'h2: b = `UCSM_BAUD_2;
            4'h3: b = `UCSM_BAUD_3;
            4'h4: b = `UCSM_BAUD_4;
            4'h5: b = `UCSM_BAUD_5;
            4'h6: b = `UCSM_BAUD_6;
            4'h7: b = `UCSM_BAUD_7;
            4'h8: b = `UCSM_BAUD_8;
            4'h9: b = `UCSM_BAUD_9;
            4'ha: b = `UCSM_BAUD_10;
            4'hb: b = `UCSM_BAUD_11;
            4'hc: b = `UCSM_BAUD_12;
            4'hd: b = `UCSM_BAUD_13;
            default: b = 32'h0;
         endcase
         d = (b == 32'h0) ? (MODULE_CLOCK_HZ * 2) / `UCSM_BAUD_X2 : MODULE_CLOCK_HZ / b;
         div_of = d[CW-1:0] - 1'b1;
      end
   endfunction

   wire [CW-1:0] bit_div  = div_of(ctrl_q[`UCSM_C_BAUD_HI:`UCSM_C_BAUD_LO]);
   wire [CW-1:0] half_div = {1'b0, bit_div[CW-1:1]};
   wire [3:0]    nbits    = {2'b00, ctrl_q[6:5]} + 4'h5;
   wire          par_on   = ctrl_q[`UCSM_C_PAR_ON];
   wire          par_even = ctrl_q[`UCSM_C_PAR_EVEN];

   // ----------------------------------------
   // Data buffers
   // ----------------------------------------
   wire       txb_ready;
   wire       txb_valid;
   wire [7:0] txb_data;
   wire       txb_pop;
   wire       rxb_ready;
   wire       rxb_valid;
   wire [7:0] rxb_data;
   reg        rx_push;
   reg  [7:0] rx_word;
   ucsm_buf #(.W(8), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_txb (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .in_valid_i  (wr_tx),
      .in_ready_o  (txb_ready),
      .in_data_i   (reg_wdata_i[7:0]),
      .out_valid_o (txb_valid),
      .out_ready_i (txb_pop),
      .out_data_o  (txb_data)
   );
   ucsm_buf #(.W(8), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_rxb (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .in_valid_i  (rx_push),
      .in_ready_o  (rxb_ready),
      .in_data_i   (rx_word),
      .out_valid_o (rxb_valid),
      .out_ready_i (rd_rx),
      .out_data_o  (rxb_data)
   );

   // ----------------------------------------
   // Transmit shifter
   // ----------------------------------------
   reg [2:0]    tx_st_q;
   reg [CW-1:0] tx_cnt_q;
   reg [7:0]    tx_sh_q;
   reg [3:0]    tx_n_q;
   reg          tx_par_q;
   reg          tx_line;
   wire tx_tick = (tx_cnt_q == {CW{1'b0}});
   assign txb_pop = (tx_st_q == S_IDLE) & ctrl_q[`UCSM_C_TX_EN] & ~rst_q
                    & ~ctrl_q[`UCSM_C_BREAK];
   always @* begin
      case (tx_st_q)
         S_START: tx_line = 1'b0;
         S_DATA:  tx_line = tx_sh_q[0];
         S_PAR:   tx_line = tx_par_q ^ ~par_even;
         default: tx_line = 1'b1;
      endcase
   end
   always @(posedge mclk_i) begin
      if (reset_i) begin
         tx_st_q  <= S_IDLE;
         tx_cnt_q <= {CW{1'b0}};
         tx_sh_q  <= 8'h00;
         tx_n_q   <= 4'h0;
         tx_par_q <= 1'b0;
         txd_o    <= 1'b1;
      end else begin
         txd_o    <= ctrl_q[`UCSM_C_BREAK] ? 1'b0 : tx_line;
         tx_cnt_q <= tx_tick ? bit_div : tx_cnt_q - 1'b1;
         case (tx_st_q)
            S_IDLE: begin
               tx_cnt_q <= bit_div;
               if (txb_pop & txb_valid) begin
                  tx_sh_q  <= txb_data;
                  tx_par_q <= 1'b0;
                  tx_st_q  <= S_START;
               end
            end
            S_START:
               if (tx_tick) begin
                  tx_n_q  <= nbits;
                  tx_st_q <= S_DATA;
               end
            S_DATA:
               if (tx_tick) begin
                  tx_par_q <= tx_par_q ^ tx_sh_q[0];
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  tx_n_q   <= tx_n_q - 1'b1;
                  if (tx_n_q == 4'h1) begin
                     tx_n_q  <= ctrl_q[`UCSM_C_TWO_STOP] ? 4'h2 : 4'h1;
                     tx_st_q <= par_on ? S_PAR : S_STOP;
                  end
               end
            S_PAR:
               if (tx_tick)
                  tx_st_q <= S_STOP;
            S_STOP:
               if (tx_tick) begin
                  tx_n_q <= tx_n_q - 1'b1;
                  if (tx_n_q == 4'h1)
                     tx_st_q <= S_IDLE;
               end
            default: tx_st_q <= S_IDLE;
         endcase
      end
   end
   wire tx_done = (tx_st_q == S_STOP) & tx_tick & (tx_n_q == 4'h1);

   // ----------------------------------------
   // Receive shifter
   // ----------------------------------------
   reg [2:0]    rx_st_q;
   reg [CW-1:0] rx_cnt_q;
   reg [7:0]    rx_sh_q;
   reg [3:0]    rx_n_q;
   reg          rx_par_q;
   wire rx_tick = (rx_cnt_q == {CW{1'b0}});
   always @(posedge mclk_i) begin
      rx_push <= 1'b0;
      if (reset_i) begin
         rx_st_q  <= S_IDLE;
         rx_cnt_q <= {CW{1'b0}};
         rx_sh_q  <= 8'h00;
         rx_n_q   <= 4'h0;
         rx_par_q <= 1'b0;
         rx_word  <= 8'h00;
         perr_q   <= 1'b0;
         ferr_q   <= 1'b0;
      end else begin
         rx_cnt_q <= rx_tick ? bit_div : rx_cnt_q - 1'b1;
         case (rx_st_q)
            S_IDLE: begin
               rx_cnt_q <= half_div;
               if (~rxd & ctrl_q[`UCSM_C_RX_EN] & ~rst_q)
                  rx_st_q <= S_START;
            end
            S_START:
               if (rx_tick) begin
                  rx_n_q   <= nbits;
                  rx_par_q <= 1'b0;
                  rx_sh_q  <= 8'h00;
                  rx_st_q  <= rxd ? S_IDLE : S_DATA;
               end
            S_DATA:
               if (rx_tick) begin
                  rx_par_q <= rx_par_q ^ rxd;
                  rx_sh_q  <= {rxd, rx_sh_q[7:1]};
                  rx_n_q   <= rx_n_q - 1'b1;
                  if (rx_n_q == 4'h1)
                     rx_st_q <= par_on ? S_PAR : S_STOP;
               end
            S_PAR:
               if (rx_tick) begin
                  perr_q  <= rx_par_q ^ rxd ^ ~par_even;
                  rx_st_q <= S_STOP;
               end
            S_STOP:
               if (rx_tick) begin
                  ferr_q  <= ~rxd;
                  rx_word <= rx_sh_q >> (4'h8 - nbits);
                  rx_push <= 1'b1;
                  rx_st_q <= S_IDLE;
               end
            default: rx_st_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Control, modem, reset flag, interrupts
   // ----------------------------------------
   always @(posedge mclk_i) begin
      s1_q <= {dtr_i, rts_i, dcd_i, rxd_i};
      s2_q <= s1_q;
      if (reset_i) begin
         ctrl_q    <= `UCSM_CTRL_RESET;
         modem_q   <= `UCSM_MODEM_RESET;
         rst_q     <= 1'b1;
         rst_cnt_q <= {CW{1'b0}};
         rx_irq_q  <= 1'b0;
         tx_irq_q  <= 1'b0;
         derr_q    <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_q <= reg_wdata_i & `UCSM_CTRL_MASK;
         if (reg_wr_i & (reg_addr_i == `UCSM_OFS_MODEM))
            modem_q <= reg_wdata_i[5:0];
         if (rst_q) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
            if (rst_cnt_q == bit_div)
               rst_q <= 1'b0;
         end
         tx_irq_q <= tx_done | (tx_irq_q & ~rd_ctrl);
         rx_irq_q <= rx_push | (rx_irq_q & ~rd_rx);
         if (rx_push & ~rxb_ready)
            derr_q <= 1'b1;
         else if (rxb_ready)
            derr_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Registered outputs and read data
   // ----------------------------------------
   wire [17:0] status = {1'b0,
      tx_st_q == S_IDLE,
      rst_q,
      tx_cnt_q > half_div,
      rx_st_q == S_IDLE,
      rx_cnt_q > half_div,
      dsr_in, cts_in, dcd_in,
      derr_q, ferr_q, perr_q, tx_irq_q, 1'b0,
      ~txb_ready, ~txb_valid, ~rxb_ready, ~rxb_valid};
   wire dsr_rd = modem_q[`UCSM_M_DTR_OUT] ? modem_q[`UCSM_M_DTR] : dsr_in;
   wire no_mdm = (MODEM_EN == 0);
   always @(posedge mclk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 18'h00000;
         rx_irq_o    <= 1'b0;
         tx_irq_o    <= 1'b0;
         dcd_o       <= 1'b1;
         dcd_oe_o    <= 1'b1;
         rts_o       <= 1'b1;
         rts_oe_o    <= 1'b1;
         dtr_o       <= 1'b1;
         dtr_oe_o    <= 1'b1;
      end else begin
         rx_irq_o <= rx_irq_q & ctrl_q[`UCSM_C_RECEIVE_IRQ_ENABLE];
         tx_irq_o <= tx_irq_q & ctrl_q[`UCSM_C_TRANSMIT_IRQ_ENABLE];
         dcd_oe_o <= modem_q[`UCSM_M_CARRIER_LINE_OUTPUT] | no_mdm;
         rts_oe_o <= modem_q[`UCSM_M_RTS_OUT] | no_mdm;
         dtr_oe_o <= modem_q[`UCSM_M_DTR_OUT] | no_mdm;
         dtr_o    <= modem_q[`UCSM_M_DTR] | no_mdm;
         rts_o    <= modem_q[`UCSM_M_RTS] | no_mdm;
         dcd_o    <= modem_q[`UCSM_M_DCD] | no_mdm;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `UCSM_OFS_STATUS: reg_rdata_o <= status;
               `UCSM_OFS_RXDATA: reg_rdata_o <= {10'h000, rxb_valid ? rxb_data : 8'h00};
               `UCSM_OFS_CTRL:   reg_rdata_o <= ctrl_q;
               `UCSM_OFS_MODEM:  reg_rdata_o <= {12'h000, modem_q[5:1], dsr_rd};
               default:          reg_rdata_o <= 18'h00000;
            endcase
         end
      end
   end
endmodule

// ==== verilog/ucsm_defines.vh ====
// Offsets, fields, reset values and rates of the UART control unit
`ifndef UCSM_DEFINES_VH
`define UCSM_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UCSM_OFS_STATUS   3'h0
`define UCSM_OFS_RXDATA   3'h1
`define UCSM_OFS_TXDATA   3'h2
`define UCSM_OFS_CTRL     3'h3
`define UCSM_OFS_MODEM    3'h4

// ----------------------------------------
// Control fields
// ----------------------------------------
`define UCSM_C_RX_EN      0
`define UCSM_C_TX_EN      1
`define UCSM_C_PAR_ON     2
`define UCSM_C_PAR_EVEN   3
`define UCSM_C_TWO_STOP   4
`define UCSM_C_LEN_LO     5
`define UCSM_C_LEN_HI     7
`define UCSM_C_BAUD_LO    9
`define UCSM_C_BAUD_HI    12
`define UCSM_C_RECEIVE_IRQ_ENABLE      13
`define UCSM_C_TRANSMIT_IRQ_ENABLE      14
`define UCSM_C_BREAK      15
`define UCSM_CTRL_RESET   18'h00000
`define UCSM_CTRL_MASK    18'h0feff

// ----------------------------------------
// Modem fields
// ----------------------------------------
`define UCSM_M_DTR        0
`define UCSM_M_RTS        1
`define UCSM_M_DCD        2
`define UCSM_M_CARRIER_LINE_OUTPUT    3
`define UCSM_M_RTS_OUT    4
`define UCSM_M_DTR_OUT    5
`define UCSM_MODEM_RESET  6'h00

// ----------------------------------------
// Status fields
// ----------------------------------------
`define UCSM_S_RX_CLK     12
`define UCSM_S_RX_IDLE    13
`define UCSM_S_TX_CLK     14
`define UCSM_S_RST        15
`define UCSM_S_TX_IDLE    16

// ----------------------------------------
// Bit rates, code order
// ----------------------------------------
`define UCSM_CLK_HZ       25000000
`define UCSM_BAUD_0       115200
`define UCSM_BAUD_1       57600
`define UCSM_BAUD_2       38400
`define UCSM_BAUD_3       31250
`define UCSM_BAUD_4       19200
`define UCSM_BAUD_5       9600
`define UCSM_BAUD_6       4800
`define UCSM_BAUD_7       2400
`define UCSM_BAUD_8       1200
`define UCSM_BAUD_9       600
`define UCSM_BAUD_10      300
`define UCSM_BAUD_11      150
`define UCSM_BAUD_12      75
`define UCSM_BAUD_13      50
`define UCSM_BAUD_X2      15625

`endif

// ==== dv/ucsm_uart_monitor.sv ====
// Port checker for the UART control unit
`timescale 1ns/100ps
module ucsm_uart_monitor #(
   parameter MODULE_CLOCK_HZ = 25000000,
   parameter MODEM_EN        = 0
) (
   input wire        mclk_i,
   input wire        reset_i,
   input wire [2:0]  reg_addr_i,
   input wire [17:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [17:0] reg_rdata_o,
   input wire        txd_o,
   input wire        rx_irq_o,
   input wire        tx_irq_o,
   input wire        dcd_o,
   input wire        dcd_oe_o,
   input wire        rts_o,
   input wire        rts_oe_o,
   input wire        dtr_o,
   input wire        dtr_oe_o
);
   // ----------------------------------------
   // Written values and reset age
   // ----------------------------------------
   localparam BITC = MODULE_CLOCK_HZ / 115200;
   reg  [17:0] ctl_q;
   reg  [5:0]  mdm_q;
   reg  [15:0] rcnt_q;
   wire        rd_st = reg_rd_i && reg_addr_i == 3'h0;
   always @(posedge mclk_i) begin
      if (reset_i) begin
         ctl_q  <= 18'h00000;
         mdm_q  <= 6'h00;
         rcnt_q <= 16'h0000;
      end else begin
         if (reg_wr_i && reg_addr_i == 3'h3)
            ctl_q <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == 3'h4)
            mdm_q <= reg_wdata_i[5:0];
         if (rcnt_q != 16'hffff)
            rcnt_q <= rcnt_q + 16'h0001;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_rst_flag_on: assert property (rd_st && rcnt_q < BITC - 2 |=> reg_rdata_o[15])
      else $error("reset flag low too early");
   a_rst_flag_off: assert property (rd_st && rcnt_q > BITC + 2 |=> !reg_rdata_o[15])
      else $error("reset flag held too long");
   a_rx_upper_zero: assert property (
      reg_rd_i && reg_addr_i == 3'h1 |=> reg_rdata_o[17:8] == 10'h000)
      else $error("receive data upper bits set");
   a_unused_zero: assert property (rd_st |=> !reg_rdata_o[17])
      else $error("unused status bit set");
   a_break_low: assert property (ctl_q[15] [*3] |-> !txd_o)
      else $error("line not low during break");
   a_txirq_gate: assert property (!ctl_q[14] [*3] |-> !tx_irq_o)
      else $error("transmit irq while disabled");
   a_rxirq_gate: assert property (!ctl_q[13] [*3] |-> !rx_irq_o)
      else $error("receive irq while disabled");
   a_txirq_clear: assert property (reg_rd_i && reg_addr_i == 3'h3 |=> ##1 !tx_irq_o)
      else $error("transmit irq kept after control read");
   a_rxirq_clear: assert property (reg_rd_i && reg_addr_i == 3'h1 |=> ##1 !rx_irq_o)
      else $error("receive irq kept after data read");
   a_mdm_dir: assert property (
      $stable(mdm_q) [*4] |-> (MODEM_EN == 0 ? {dcd_oe_o, rts_oe_o, dtr_oe_o} == 3'h7 :
      {dcd_oe_o, rts_oe_o, dtr_oe_o} == {mdm_q[3], mdm_q[4], mdm_q[5]}))
      else $error("handshake direction wrong");
   a_mdm_level: assert property (
      $stable(mdm_q) [*4] |-> (MODEM_EN == 0 ? {dcd_o, rts_o, dtr_o} == 3'h7 :
      (!mdm_q[3] || dcd_o == mdm_q[2]) && (!mdm_q[4] || rts_o == mdm_q[1])
      && (!mdm_q[5] || dtr_o == mdm_q[0])))
      else $error("handshake level wrong");
   c_break: cover property (ctl_q[15] && !txd_o);
   c_tx_irq: cover property (tx_irq_o);
   c_rx_irq: cover property (rx_irq_o);
endmodule

bind ucsm_uart ucsm_uart_monitor #(
   .MODULE_CLOCK_HZ(MODULE_CLOCK_HZ),
   .MODEM_EN(MODEM_EN)
) u_mon (
   .mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .txd_o(txd_o),
   .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .dcd_o(dcd_o), .dcd_oe_o(dcd_oe_o),
   .rts_o(rts_o), .rts_oe_o(rts_oe_o), .dtr_o(dtr_o), .dtr_oe_o(dtr_oe_o)
);

// ==== dv/ucsm_term.sv ====
// Serial terminal model facing the UART line pins
`timescale 1ns/100ps
module ucsm_term (
   input  wire mclk_i,
   input  wire line_i,
   output reg  line_o
);
   initial line_o = 1'b1;
   // Sends start, data LSB first, optional parity, one stop
   task send(input [7:0] d, input integer n, input p_on, input p_ev, input integer bc);
      integer i;
      reg     par;
      begin
         par = ^(d & (8'hff >> (8 - n))) ^ !p_ev;
         @(posedge mclk_i);
         for (i = 0; i < n + p_on + 2; i = i + 1) begin
            line_o <= i == 0 ? 1'b0 : i <= n ? d[i-1] : (p_on && i == n + 1) ? par : 1'b1;
            repeat (bc) @(posedge mclk_i);
         end
      end
   endtask
   // Samples one frame at mid-bit
   task recv(output [7:0] d, output pb, output ok, input integer n, input p_on,
             input integer ns, input integer bc);
      integer i;
      begin
         d = 8'h00;
         pb = 1'b0;
         @(negedge line_i);
         repeat (bc / 2) @(posedge mclk_i);
         ok = !line_i;
         for (i = 0; i < n + p_on + ns; i = i + 1) begin
            repeat (bc) @(posedge mclk_i);
            if (i < n)
               d[i] = line_i;
            else if (p_on && i == n)
               pb = line_i;
            else
               ok = ok & line_i;
         end
      end
   endtask
   // Length of the first low run in clock cycles
   task meas(output integer len);
      time t0;
      begin
         @(negedge line_i);
         t0 = $time;
         @(posedge line_i);
         len = ($time - t0) / 8;
      end
   endtask
endmodule

// ==== dv/ucsm_uart_tb.sv ====
// Self-checking bench for the UART control unit
`timescale 1ns/100ps
`include "ucsm_defines.vh"
module ucsm_uart_tb;
   localparam CLK = 1152000;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [2:0]  addr = 3'h0;
   reg  [17:0] wdata = 18'h00000;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   reg  [2:0]  hs = 3'h7;
   wire [17:0] rdata;
   wire        txd, rxd, rx_irq, tx_irq, dcd_o, dcd_oe, rts_o, rts_oe, dtr_o, dtr_oe;
   wire        dcd_w = dcd_oe ? dcd_o : hs[0];
   wire        rts_w = rts_oe ? rts_o : hs[1];
   wire        dtr_w = dtr_oe ? dtr_o : hs[2];
   integer     n_fail = 0;
   integer     checked = 0;
   integer     cyc = 0;
   integer     i, j, k, n, len;
   reg  [31:0] rnd = 32'h53df;
   reg  [17:0] s, v;
   reg  [7:0]  b0, b1, g0, g1, m;
   reg  [7:0]  bq [0:2];
   reg  [2:0]  sn;
   reg         p0, p1, k0, k1;

   ucsm_uart #(.MODULE_CLOCK_HZ(CLK), .MODEM_EN(1)) dut (
      .mclk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .rxd_i(rxd), .txd_o(txd), .rx_irq_o(rx_irq),
      .tx_irq_o(tx_irq), .dcd_i(dcd_w), .dcd_o(dcd_o), .dcd_oe_o(dcd_oe), .rts_i(rts_w),
      .rts_o(rts_o), .rts_oe_o(rts_oe), .dtr_i(dtr_w), .dtr_o(dtr_o), .dtr_oe_o(dtr_oe)
   );
   ucsm_term term (.mclk_i(clk), .line_i(txd), .line_o(rxd));

   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         n_fail = n_fail + 1;
         $display("[ERR] %0t timeout", $time);
         summarize;
      end
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function [17:0] bitc(input [3:0] c);
      case (c)
         0: bitc = CLK / `UCSM_BAUD_0;
         1: bitc = CLK / `UCSM_BAUD_1;
         2: bitc = CLK / `UCSM_BAUD_2;
         3: bitc = CLK / `UCSM_BAUD_3;
         4: bitc = CLK / `UCSM_BAUD_4;
         5: bitc = CLK / `UCSM_BAUD_5;
         6: bitc = CLK / `UCSM_BAUD_6;
         7: bitc = CLK / `UCSM_BAUD_7;
         8: bitc = CLK / `UCSM_BAUD_8;
         default: bitc = 2 * CLK / 15625;
      endcase
   endfunction
   task wreg(input [2:0] a, input [17:0] d);
      begin
         @(posedge clk);
         addr  <= a;
         wdata <= d;
         wr    <= 1'b1;
         @(posedge clk);
         wr    <= 1'b0;
      end
   endtask
   task rreg(input [2:0] a, output [17:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd   <= 1'b1;
         @(posedge clk);
         rd   <= 1'b0;
         #1 d = rdata;
      end
   endtask
   task chk(input [17:0] got, input [17:0] exp, input [8*12-1:0] what);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t %0s got %h exp %h", $time, what, got, exp);
         end
      end
   endtask
   task cfg(input [17:0] c);
      begin
         s = 18'h00000;
         k = 0;
         while ((s & 18'h1a005) !== 18'h12005 && k < 12000) begin
            rreg(3'h0, s);
            k = k + 1;
         end
         wreg(3'h3, c);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rreg(3'h0, s);
      chk(s[15], 1'b1, "rst flag");
      rreg(3'h3, s);
      chk(s, 18'h00000, "ctrl reset");
      rreg(3'h4, s);
      chk(s, 18'h00001, "modem reset");
      repeat (20) @(posedge clk);
      rreg(3'h0, s);
      chk(s & 18'h3a005, 18'h12005, "idle status");
      $display("reset test done");
      for (i = 0; i < 11; i = i + 1) begin
         j = i < 9 ? i : i + 5;
         cfg(18'h000e2 | {j[3:0], 9'h000});
         wreg(3'h2, 18'h00055);
         term.meas(len);
         chk(len[17:0], bitc(j[3:0]), "bit period");
      end
      $display("rate test done");
      for (i = 0; i < 8; i = i + 1) begin
         rnd = lfsr(rnd);
         v = {3'h0, rnd[1], 5'h00, 1'b0, 1'b1, rnd[3:2], rnd[4], rnd[5], rnd[6], 2'b10};
         n = 5 + v[6:5];
         m = 8'hff >> (8 - n);
         b0 = rnd[15:8];
         b1 = rnd[23:16];
         sn = 3'h0;
         cfg(v);
         fork
            begin
               term.recv(g0, p0, k0, n, v[2], v[4] + 1, 10);
               term.recv(g1, p1, k1, n, v[2], v[4] + 1, 10);
            end
            begin
               wreg(3'h2, {rnd[31:22], b0});
               wreg(3'h2, {rnd[9:0], b1});
               repeat (16) begin
                  rreg(3'h0, s);
                  sn = sn | {!s[16], s[14], !s[14]};
               end
            end
         join
         chk({k0, k1, g0, g1}, {2'b11, b0 & m, b1 & m}, "tx frame");
         if (v[2])
            chk({p0, p1}, {^(b0 & m) ^ !v[3], ^(b1 & m) ^ !v[3]}, "parity");
         chk(sn, 3'h7, "tx status");
         repeat (20) @(posedge clk);
         chk(tx_irq, v[14], "tx irq");
         rreg(3'h3, s);
         @(posedge clk);
         #1 chk(tx_irq, 1'b0, "tx irq clr");
      end
      $display("transmit test done");
      rnd = lfsr(rnd);
      v = {5'h01, 5'h00, 1'b1, rnd[3:2], 1'b0, rnd[5], rnd[6], 2'b01};
      n = 5 + v[6:5];
      m = 8'hff >> (8 - n);
      sn = 3'h0;
      cfg(v);
      for (i = 0; i < 3; i = i + 1) begin
         rnd = lfsr(rnd);
         bq[i] = rnd[7:0];
         fork
            term.send(bq[i], n, v[2], v[3], 10);
            repeat (12) begin
               rreg(3'h0, s);
               sn = sn | {!s[13], s[12], !s[12]};
            end
         join
         repeat (20) @(posedge clk);
      end
      rreg(3'h0, s);
      chk({rx_irq, s[8:6], s[1]}, 5'b11001, "rx full");
      chk(sn, 3'h7, "rx status");
      for (i = 0; i < 2; i = i + 1) begin
         rreg(3'h1, s);
         chk(s, {10'h000, bq[i] & m}, "rx data");
         @(posedge clk);
         #1 chk(rx_irq, 1'b0, "rx irq clr");
      end
      cfg(18'h000e0);
      term.send(8'h5a, 8, 1'b0, 1'b0, 10);
      repeat (20) @(posedge clk);
      rreg(3'h0, s);
      chk(s[0], 1'b1, "rx off");
      $display("receive test done");
      cfg(18'h08002);
      repeat (12) begin
         repeat (10) @(posedge clk);
         chk(txd, 1'b0, "break");
      end
      cfg(18'h00002);
      repeat (4) @(posedge clk);
      chk(txd, 1'b1, "break end");
      $display("break test done");
      for (i = 0; i < 16; i = i + 1) begin
         rnd = lfsr(rnd);
         @(posedge clk);
         hs <= rnd[8:6];
         wreg(3'h4, {12'h000, rnd[5:0]});
         repeat (4) @(posedge clk);
         #1 chk({dcd_oe, rts_oe, dtr_oe}, {rnd[3], rnd[4], rnd[5]}, "dir");
         chk({dcd_w, rts_w, dtr_w}, {rnd[3] ? rnd[2] : hs[0], rnd[4] ? rnd[1] : hs[1],
             rnd[5] ? rnd[0] : hs[2]}, "level");
         rreg(3'h4, s);
         chk(s, {12'h000, rnd[5:1], rnd[5] ? rnd[0] : hs[2]}, "modem rd");
      end
      $display("modem test done");
      summarize;
   end
endmodule
